// ===== src/tmc_core.sv
// Functional notes
// R1: Sixteen-bit counter steps up or down by exactly one per enabled tick.
// R2: A clear forces every count bit to zero.
// R3: TOP flag when count equals current maximum, BOTTOM flag when zero.
// R4: High-byte location reads and writes reach a shared latch, not the counter.
// R5: Reading the low byte copies the counter's upper byte into the latch.
// R6: Writing the low byte loads the upper byte from the latch at once.
// R7: A software count write beats any clear or step in that cycle.
// R8: Clock source zero stops counting; the count stays readable and writable.
// R9: Source codes 1 to 5 give undivided, /8, /64, /256, /1024 ticks.
// R10: Code 6 counts falling pin edges, code 7 rising pin edges.
// R11: Pin edges count even when that pin is driven as an output.
// R12: The four-bit waveform mode, split over two registers, sets the sequence.
// R13: Modes with capture as TOP disconnect the capture input.
// R14: Software writes zero to reserved bit 5 of control B.
// R15: Clock select lives in bits 2 to 0 of control B.
// R16: Force bits 7 and 6 of control C act only in non-PWM modes.
// R17: Writing a force bit forces a match; output follows its action bits.
// R18: Force bits are one-cycle strobes, never stored.
// R19: Software writes zero force bits while a PWM mode runs.
// R20: Prescaler taps are one-cycle enables from a free-running counter.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`include "tmc_params.svh"
module tmc_core
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM register slave.
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // External count pin, asynchronous.
    input  wire logic        external_count_pin,
    // TOP sources from the compare and capture units.
    input  wire logic [15:0] compare_a_value,
    input  wire logic [15:0] capture_register,
    // Counter state.
    output logic      [15:0] count_value,
    output logic             top_flag,
    output logic             bottom_flag,
    output logic             count_down,
    // Waveform unit strobes and outputs.
    output logic             force_compare_a,
    output logic             force_compare_b,
    output logic             compare_output_a,
    output logic             compare_output_b,
    output logic             capture_enable
);
    import tmc_pkg::*;

    // Mode table: TOP source, dual slope, PWM.
    function automatic tmc_mode_t mode_info(input logic [3:0] m);
        tmc_mode_t i;
        i = '{TMC_TOP_SRC_FULL, 1'b0, 1'b0};
        case (m)
            4'h0: i = '{TMC_TOP_SRC_FULL, 1'b0, 1'b0};
            4'h1: i = '{TMC_TOP_SRC_8BIT, 1'b1, 1'b1};
            4'h2: i = '{TMC_TOP_SRC_9BIT, 1'b1, 1'b1};
            4'h3: i = '{TMC_TOP_SRC_10BIT, 1'b1, 1'b1};
            4'h4: i = '{TMC_TOP_SRC_CMP, 1'b0, 1'b0};
            4'h5: i = '{TMC_TOP_SRC_8BIT, 1'b0, 1'b1};
            4'h6: i = '{TMC_TOP_SRC_9BIT, 1'b0, 1'b1};
            4'h7: i = '{TMC_TOP_SRC_10BIT, 1'b0, 1'b1};
            4'h8: i = '{TMC_TOP_SRC_CAP, 1'b1, 1'b1};
            4'h9: i = '{TMC_TOP_SRC_CMP, 1'b1, 1'b1};
            4'ha: i = '{TMC_TOP_SRC_CAP, 1'b1, 1'b1};
            4'hb: i = '{TMC_TOP_SRC_CMP, 1'b1, 1'b1};
            4'hc: i = '{TMC_TOP_SRC_CAP, 1'b0, 1'b0};
            4'he: i = '{TMC_TOP_SRC_CAP, 1'b0, 1'b1};
            4'hf: i = '{TMC_TOP_SRC_CMP, 1'b0, 1'b1};
            default: i = '{TMC_TOP_SRC_FULL, 1'b0, 1'b0};
        endcase
        return i;
    endfunction : mode_info

    // Registers and state.
    tmc_bus_st_t bus_st_q;
    tmc_bus_st_t bus_st_d;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0]  hi_latch_q;
    logic        down_q;
    logic        top_q;
    logic        bottom_q;
    logic        cap_en_q;
    logic [1:0]  force_q;
    logic [1:0]  oc_q;
    logic [1:0]  oc_d;
    tmc_csel_t   csel;
    tmc_mode_t   mode;
    logic [15:0] top_sel;
    logic [7:0]  rd_byte;
    // Tick carrier; declared early because the count enable below reads it.
    tmc_tick_if  tk ();

    // Bus handshake decode: one wait cycle, then the answer cycle.
    wire bus_req   = avs_read | avs_write;
    wire accept    = bus_req & (bus_st_q == TMC_BUS_IDLE);
    wire complete  = bus_st_q == TMC_BUS_ACK;
    wire wr_fire   = complete & avs_write & avs_byteenable[0];
    wire rd_accept = accept & avs_read;
    wire [7:0] wdat = avs_writedata[7:0];

    // Address decode.
    wire hit_a  = avs_address == `TMC_OFS_CTRL_A;
    wire hit_b  = avs_address == `TMC_OFS_CTRL_B;
    wire hit_c  = avs_address == `TMC_OFS_CTRL_C;
    wire hit_lo = avs_address == `TMC_OFS_CNT_LO;
    wire hit_hi = avs_address == `TMC_OFS_CNT_HI;
    wire hit_st = avs_address == `TMC_OFS_STATUS;
    wire wr_a   = wr_fire & hit_a;
    wire wr_b   = wr_fire & hit_b;
    wire wr_c   = wr_fire & hit_c;
    wire wr_lo  = wr_fire & hit_lo;
    wire wr_hi  = wr_fire & hit_hi;
    wire rd_lo  = rd_accept & hit_lo;

    // Mode, clock select and TOP selection.
    wire [3:0] wgm = {ctrl_b_q[`TMC_B_WGM_HI], ctrl_a_q[`TMC_A_WGM_LO]}; // R12
    assign mode = mode_info(wgm); // R12
    assign csel = tmc_csel_t'(ctrl_b_q[`TMC_B_CSEL]); // R15
    assign top_sel = (mode.src == TMC_TOP_SRC_CMP)   ? compare_a_value :
                     (mode.src == TMC_TOP_SRC_CAP)   ? capture_register :
                     (mode.src == TMC_TOP_SRC_8BIT)  ? `TMC_TOP_8BIT :
                     (mode.src == TMC_TOP_SRC_9BIT)  ? `TMC_TOP_9BIT :
                     (mode.src == TMC_TOP_SRC_10BIT) ? `TMC_TOP_10BIT :
                     `TMC_TOP_FULL;

    // Read mux; control C is write-only and reads zero.
    wire [7:0] status_byte = {4'h0, ~cap_en_q, down_q, bottom_q, top_q};
    assign rd_byte = hit_a  ? ctrl_a_q :
                     hit_b  ? ctrl_b_q :
                     hit_lo ? count_q[7:0] :
                     hit_hi ? hi_latch_q : // R4
                     hit_st ? status_byte :
                     8'h00;

    // Bus slave state machine.
    always_comb
    begin
        case (bus_st_q)
            TMC_BUS_IDLE: bus_st_d = bus_req ? TMC_BUS_ACK : TMC_BUS_IDLE;
            TMC_BUS_ACK:  bus_st_d = TMC_BUS_IDLE;
            default:      bus_st_d = TMC_BUS_IDLE;
        endcase
    end

    // Read data is caught on acceptance so it stands through the answer cycle.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bus_st_q <= TMC_BUS_IDLE;
            wait_q   <= 1'b1;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            bus_st_q <= bus_st_d;
            wait_q   <= ~accept;
            if (rd_accept)
                rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // Control registers keep reserved bits at zero whatever is written.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_a_q <= `TMC_RST_CTRL;
            ctrl_b_q <= `TMC_RST_CTRL;
        end
        else
        begin
            if (wr_a)
                ctrl_a_q <= wdat & `TMC_A_WMASK;
            if (wr_b)
                ctrl_b_q <= wdat & `TMC_B_WMASK; // R14
        end
    end

    // The latch is loaded on the low-byte read, so the pair reads coherently.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hi_latch_q <= `TMC_RST_LATCH;
        else if (wr_hi)
            hi_latch_q <= wdat; // R4
        else if (rd_lo)
            hi_latch_q <= count_q[15:8]; // R5
    end

    // Count enable, wrap and slope decisions.
    wire tick_fire = tk.tick & (csel != TMC_CS_STOP); // R8
    wire at_top    = count_q == top_sel;
    wire at_bottom = count_q == 16'h0000;
    wire wrap      = tick_fire & ~mode.dual & at_top; // R2
    wire go_down   = mode.dual & (at_top | (down_q & ~at_bottom)); // R12

    // Next count: a software write wins over any wrap or step.
    always_comb
    begin
        count_d = count_q;
        if (wr_lo)
            count_d = {hi_latch_q, wdat}; // R6 R7
        else if (wrap)
            count_d = `TMC_RST_COUNT; // R2
        else if (tick_fire)
            count_d = go_down ? count_q - 16'h0001 : count_q + 16'h0001; // R1
    end

    // Counter, direction and end flags; flags follow the value being stored.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_q  <= `TMC_RST_COUNT;
            down_q   <= 1'b0;
            top_q    <= 1'b0;
            bottom_q <= 1'b1;
        end
        else
        begin
            count_q  <= count_d;
            if (!mode.dual)
                down_q <= 1'b0;
            else if (tick_fire && !wr_lo)
                down_q <= go_down; // R1
            top_q    <= count_d == top_sel; // R3
            bottom_q <= count_d == 16'h0000; // R3
        end
    end

    // Capture input is cut off whenever capture supplies TOP.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cap_en_q <= 1'b1;
        else
            cap_en_q <= mode.src != TMC_TOP_SRC_CAP; // R13
    end

    // Force strobes exist for one cycle only; in PWM modes they are ignored.
    wire [1:0] force_hit = {wr_c & wdat[`TMC_C_FORCE_A], wr_c & wdat[`TMC_C_FORCE_B]} & {2{~mode.pwm}}; // R16 R18

    // Per channel: index 1 is channel A, index 0 is channel B.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            wire [1:0] act = ctrl_a_q[`TMC_A_COA_LSB + 2 * ch +: 2];
            assign oc_d[ch] = (act == TMC_COA_TOGGLE) ? ~oc_q[ch] : // R17
                              (act == TMC_COA_CLEAR)  ? 1'b0 :
                              (act == TMC_COA_SET)    ? 1'b1 :
                              oc_q[ch];
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    force_q[ch] <= 1'b0;
                    oc_q[ch]    <= 1'b0;
                end
                else
                begin
                    force_q[ch] <= force_hit[ch]; // R18
                    if (force_hit[ch])
                        oc_q[ch] <= oc_d[ch]; // R17
                end
            end
        end
    endgenerate

    // Clock source selection and prescaler.
    assign tk.source = csel;
    tmc_tick_gen u_tick
    (
        .clk     (clk),
        .rst     (rst),
        .ext_pin (external_count_pin),
        .tk      (tk.gen)
    );

    // Outputs, all from flip-flops.
    assign avs_readdata     = rdata_q;
    assign avs_waitrequest  = wait_q;
    assign count_value      = count_q;
    assign top_flag         = top_q;
    assign bottom_flag      = bottom_q;
    assign count_down       = down_q;
    assign force_compare_a  = force_q[1];
    assign force_compare_b  = force_q[0];
    assign compare_output_a = oc_q[1];
    assign compare_output_b = oc_q[0];
    assign capture_enable   = cap_en_q;

    // Checks.
    wire [7:0] count_hi = count_q[15:8];

    default clocking core_clk @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    sequence seq_strobe_a;
        force_compare_a ##1 !force_compare_a;
    endsequence

    AST_BUS_ANSWER: assert property (accept |=> seq_answer)
        else $error("Bus request not answered after one wait cycle.");
    AST_STEP: assert property (tick_fire && !wr_lo && !wrap |=> // R1
        (count_q == $past(count_q) + 16'h0001) || (count_q == $past(count_q) - 16'h0001))
        else $error("Count did not move by exactly one.");
    AST_CLEAR: assert property (wrap && !wr_lo |=> count_q == 16'h0000) // R2
        else $error("Wrap did not clear the count.");
    AST_TOP: assert property (!$past(rst) && $stable(top_sel) |-> top_flag == (count_q == top_sel)) // R3
        else $error("TOP flag disagrees with count.");
    AST_BOTTOM: assert property (bottom_flag == (count_q == 16'h0000)) // R3
        else $error("BOTTOM flag disagrees with count.");
    AST_HI_WRITE: assert property (wr_hi |=> hi_latch_q == $past(wdat)) // R4
        else $error("High-byte write missed the latch.");
    AST_LATCH: assert property (rd_lo |=> hi_latch_q == $past(count_hi)) // R5
        else $error("Low-byte read did not latch the high byte.");
    AST_LOW_WRITE: assert property (wr_lo |=> count_q == {$past(hi_latch_q), $past(wdat)}) // R6 R7
        else $error("Low-byte write did not load the full count.");
    AST_STOP: assert property (csel == TMC_CS_STOP && !wr_lo |=> $stable(count_q)) // R8
        else $error("Stopped counter moved.");
    AST_TURN: assert property (tick_fire && mode.dual && at_top && !at_bottom && !wr_lo |=> // R12
        count_q == $past(count_q) - 16'h0001)
        else $error("Dual-slope counter did not turn at TOP.");
    AST_CAPTURE: assert property ($stable(wgm) [*2] |-> capture_enable == (mode.src != TMC_TOP_SRC_CAP)) // R13
        else $error("Capture enable wrong for mode.");
    AST_FORCE: assert property (wr_c && wdat[`TMC_C_FORCE_A] && !mode.pwm |=> seq_strobe_a) // R17 R18
        else $error("Force strobe A not a single pulse.");
    AST_NO_FORCE: assert property (wr_c && mode.pwm |=> !force_compare_a && !force_compare_b) // R16
        else $error("Force strobe in a PWM mode.");

endmodule : tmc_core

// ===== src/tmc_params.svh
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave.
`define TMC_OFS_CTRL_A 5'h00
`define TMC_OFS_CTRL_B 5'h04
`define TMC_OFS_CTRL_C 5'h08
`define TMC_OFS_CNT_LO 5'h0c
`define TMC_OFS_CNT_HI 5'h10
`define TMC_OFS_STATUS 5'h14

// Field positions.
`define TMC_A_WGM_LO   1:0
`define TMC_B_WGM_HI   4:3
`define TMC_B_CSEL     2:0
`define TMC_C_FORCE_A  7
`define TMC_C_FORCE_B  6
`define TMC_A_COA_LSB  4

// Writable bit masks; reserved bits hold zero.
`define TMC_A_WMASK    8'hf3
`define TMC_B_WMASK    8'hdf

// Reset values.
`define TMC_RST_CTRL   8'h00
`define TMC_RST_COUNT  16'h0000
`define TMC_RST_LATCH  8'h00

// Fixed TOP values.
`define TMC_TOP_FULL   16'hffff
`define TMC_TOP_8BIT   16'h00ff
`define TMC_TOP_9BIT   16'h01ff
`define TMC_TOP_10BIT  16'h03ff

// Prescaler width and tap masks.
`define TMC_PRE_W      10
`define TMC_PRE_M8     10'h007
`define TMC_PRE_M64    10'h03f
`define TMC_PRE_M256   10'h0ff
`define TMC_PRE_M1024  10'h3ff

`endif

// ===== src/tmc_pkg.sv
package tmc_pkg;

    // Where the counter takes its TOP from.
    typedef enum logic [2:0] {
        TMC_TOP_SRC_FULL  = 3'h0,
        TMC_TOP_SRC_8BIT  = 3'h1,
        TMC_TOP_SRC_9BIT  = 3'h2,
        TMC_TOP_SRC_10BIT = 3'h3,
        TMC_TOP_SRC_CMP   = 3'h4,
        TMC_TOP_SRC_CAP   = 3'h5
    } tmc_top_src_t;

    // Decoded waveform mode.
    typedef struct packed {
        tmc_top_src_t src;
        logic         dual;
        logic         pwm;
    } tmc_mode_t;

    // Compare output action on a match.
    typedef enum logic [1:0] {
        TMC_COA_KEEP   = 2'h0,
        TMC_COA_TOGGLE = 2'h1,
        TMC_COA_CLEAR  = 2'h2,
        TMC_COA_SET    = 2'h3
    } tmc_coa_t;

    // Clock source select codes.
    typedef enum logic [2:0] {
        TMC_CS_STOP    = 3'h0,
        TMC_CS_DIV1    = 3'h1,
        TMC_CS_DIV8    = 3'h2,
        TMC_CS_DIV64   = 3'h3,
        TMC_CS_DIV256  = 3'h4,
        TMC_CS_DIV1024 = 3'h5,
        TMC_CS_EXTFALL = 3'h6,
        TMC_CS_EXTRISE = 3'h7
    } tmc_csel_t;

    // Bus slave states.
    typedef enum logic {
        TMC_BUS_IDLE = 1'b0,
        TMC_BUS_ACK  = 1'b1
    } tmc_bus_st_t;

endpackage : tmc_pkg

// ===== src/tmc_tick_if.sv
// Clock source request from the core and the resulting count enable.
interface tmc_tick_if;
    import tmc_pkg::*;
    tmc_csel_t source;
    logic      tick;
    modport gen  (input source, output tick);
    modport core (output source, input tick);
endinterface : tmc_tick_if

// ===== src/tmc_tick_gen.sv
`include "tmc_params.svh"
module tmc_tick_gen
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Raw external count pin.
    input  wire logic ext_pin,
    // Source request and tick.
    tmc_tick_if.gen   tk
);
    import tmc_pkg::*;

    logic [`TMC_PRE_W-1:0] pre_q;
    logic                  sync1_q;
    logic                  sync2_q;
    logic                  prev_q;
    logic                  tick_q;

    // Prescaler taps are enables, so every tick stays on the one clock.
    wire tap_8    = (pre_q & `TMC_PRE_M8) == `TMC_PRE_M8; // R20
    wire tap_64   = (pre_q & `TMC_PRE_M64) == `TMC_PRE_M64;
    wire tap_256  = (pre_q & `TMC_PRE_M256) == `TMC_PRE_M256;
    wire tap_1024 = (pre_q & `TMC_PRE_M1024) == `TMC_PRE_M1024;
    // The pin is watched whatever its port direction, so software can count.
    wire ext_rise = sync2_q & ~prev_q; // R11
    wire ext_fall = ~sync2_q & prev_q;
    wire tick_d   = (tk.source == TMC_CS_DIV1) // R9
                  | ((tk.source == TMC_CS_DIV8) & tap_8)
                  | ((tk.source == TMC_CS_DIV64) & tap_64)
                  | ((tk.source == TMC_CS_DIV256) & tap_256)
                  | ((tk.source == TMC_CS_DIV1024) & tap_1024)
                  | ((tk.source == TMC_CS_EXTFALL) & ext_fall) // R10
                  | ((tk.source == TMC_CS_EXTRISE) & ext_rise);

    // Free-running prescaler; it never resets between selections.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
    end

    // Pin synchroniser, edge history and registered tick.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            tick_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= ext_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            tick_q  <= tick_d;
        end
    end

    assign tk.tick = tick_q;

    default clocking gen_clk @(posedge clk); endclocking
    default disable iff (rst);

    AST_DIV8_PHASE: assert property (tick_q && $past(tk.source) == TMC_CS_DIV8 |-> pre_q[2:0] == 3'h0) // R9
        else $error("Divide-by-8 tick out of phase.");
    AST_EXT_RISE: assert property (tk.source == TMC_CS_EXTRISE && ext_rise |=> tick_q) // R10
        else $error("Rising pin edge gave no tick.");
    AST_EXT_FALL: assert property (tk.source == TMC_CS_EXTFALL && !ext_fall |=> !tick_q) // R10
        else $error("Tick without a falling pin edge.");

endmodule : tmc_tick_gen

// ===== sim/sixteen_bit_timer_counter_core_tb_top.sv
`include "tmc_params.svh"
module sixteen_bit_timer_counter_core_tb_top;
    import tmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and bus master drive.
    logic        clk           = 1'b0;
    logic        rst           = 1'b1;
    logic [4:0]  avs_address   = 5'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        ext_pin       = 1'b0;
    // Design outputs.
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] count_value;
    logic        top_flag;
    logic        bottom_flag;
    logic        count_down;
    logic        force_a;
    logic        force_b;
    logic        out_a;
    logic        out_b;
    logic        cap_en;
    // Bench bookkeeping.
    int          miscompares   = 0;
    int          tests_run     = 0;
    int          cycles        = 0;
    int          pulses_a      = 0;
    int          pulses_b      = 0;
    logic [15:0] c0;
    logic [7:0]  rd;

    // The TOP sources are tied off; no scenario runs a compare- or capture-top count.
    tmc_core i_dut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .external_count_pin(ext_pin), .compare_a_value(16'h0000),
        .capture_register(16'h0000), .count_value(count_value), .top_flag(top_flag),
        .bottom_flag(bottom_flag), .count_down(count_down), .force_compare_a(force_a),
        .force_compare_b(force_b), .compare_output_a(out_a), .compare_output_b(out_b),
        .capture_enable(cap_en)
    );

    // The clock toggles every half period of 2 ns.
    always #2 clk = ~clk;

    // Strobes are counted so that a stored or repeated strobe shows up.
    always @(posedge clk)
    begin
        if (force_a === 1'b1) pulses_a++;
        if (force_b === 1'b1) pulses_b++;
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask : check

    // One bus cycle; the request is held until waitrequest is sampled low at an edge.
    task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= ~wr;
        avs_write     <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        check("bus wait cycles", 32'h2, 32'(n));
    endtask : bus_xfer

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus_xfer(1'b1, a, d, rd);
    endtask : wr

    task automatic rdchk(input string name, input logic [4:0] a, input logic [7:0] exp);
        bus_xfer(1'b0, a, 8'h00, rd);
        check(name, {24'h0, exp}, {24'h0, rd});
    endtask : rdchk

    // Counts advanced over exactly n cycles, taken off the edge.
    task automatic ticks(input int n, input logic [15:0] exp, input string name);
        @(posedge clk);
        #1 c0 = count_value;
        repeat (n) @(posedge clk);
        #1 check(name, {16'h0, exp}, {16'h0, 16'(count_value - c0)});
    endtask : ticks

    // Forces both channels with the given action and mode settings.
    task automatic force_step(input logic [7:0] ca, input logic [7:0] cb, input logic [1:0] ab, input int np);
        wr(`TMC_OFS_CTRL_A, ca);
        wr(`TMC_OFS_CTRL_B, cb);
        wr(`TMC_OFS_CTRL_C, 8'hc0);
        repeat (2) @(posedge clk);
        #1 check("compare outputs", {30'h0, ab}, {30'h0, out_a, out_b});
        check("force strobes", 32'(np * 2), 32'(pulses_a + pulses_b));
    endtask : force_step

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // Main sequence; the prescaler table doubles as the expected tick periods.
    initial
    begin
        int div [5];
        div = '{1, 8, 64, 256, 1024};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk("status after reset", `TMC_OFS_STATUS, 8'h02);
        check("capture enable after reset", 32'h1, {31'h0, cap_en});
        check("bottom flag after reset", 32'h1, {31'h0, bottom_flag});
        wr(`TMC_OFS_CTRL_B, 8'h05);
        rdchk("control b", `TMC_OFS_CTRL_B, 8'h05);
        wr(`TMC_OFS_CTRL_B, 8'h00);
        wr(5'h18, 8'h55);
        rdchk("unmapped", 5'h18, 8'h00);
        // Whole count writes and coherent reads through the shared latch.
        wr(`TMC_OFS_CNT_HI, 8'h12);
        wr(`TMC_OFS_CNT_LO, 8'h34);
        #1 check("count after low write", 32'h1234, {16'h0, count_value});
        wr(`TMC_OFS_CNT_HI, 8'h99);
        #1 check("count after lone high write", 32'h1234, {16'h0, count_value});
        rdchk("count low", `TMC_OFS_CNT_LO, 8'h34);
        rdchk("count high", `TMC_OFS_CNT_HI, 8'h12);
        wr(`TMC_OFS_CNT_HI, 8'hff);
        wr(`TMC_OFS_CNT_LO, 8'hff);
        rdchk("status at top", `TMC_OFS_STATUS, 8'h01);
        check("top flag", 32'h1, {31'h0, top_flag});
        // A count write while running at full rate lands unchanged.
        wr(`TMC_OFS_CTRL_B, 8'h01);
        wr(`TMC_OFS_CNT_HI, 8'h40);
        wr(`TMC_OFS_CNT_LO, 8'h00);
        #1 check("count write beats tick", 32'h4000, {16'h0, count_value});
        for (int i = 0; i < 5; i++)
        begin
            wr(`TMC_OFS_CTRL_B, 8'(i + 1));
            ticks(8 * div[i], 16'h0008, "prescaled count");
        end
        // Pin edges of one polarity only advance the count.
        for (int e = 6; e < 8; e++)
        begin
            wr(`TMC_OFS_CTRL_B, 8'(e));
            // One edge lets a tick launched by the previous source land first.
            @(posedge clk);
            #1 c0 = count_value;
            repeat (8)
            begin
                @(posedge clk);
                ext_pin <= ~ext_pin;
                repeat (6) @(posedge clk);
            end
            repeat (8) @(posedge clk);
            #1 check("pin edge count", 32'h4, {16'h0, 16'(count_value - c0)});
        end
        wr(`TMC_OFS_CTRL_B, 8'h00);
        ticks(20, 16'h0000, "stopped count");
        // Dual slope 8-bit mode turns round at its TOP and steps down.
        wr(`TMC_OFS_CTRL_A, 8'h01);
        wr(`TMC_OFS_CNT_HI, 8'h00);
        wr(`TMC_OFS_CNT_LO, 8'hf0);
        wr(`TMC_OFS_CTRL_B, 8'h01);
        repeat (100) if (count_down !== 1'b1) @(posedge clk);
        check("count down", 32'h1, {31'h0, count_down});
        ticks(1, 16'hffff, "down step");
        // Single slope 8-bit mode wraps from its TOP to zero.
        wr(`TMC_OFS_CTRL_B, 8'h08);
        wr(`TMC_OFS_CNT_HI, 8'h00);
        wr(`TMC_OFS_CNT_LO, 8'hff);
        wr(`TMC_OFS_CTRL_B, 8'h09);
        ticks(8, 16'hff08, "wrap to zero");
        wr(`TMC_OFS_CTRL_B, 8'h00);
        // Forced matches follow the action present at the strobe and only outside PWM.
        force_step(8'hd0, 8'h00, 2'b11, 1);
        force_step(8'hd0, 8'h00, 2'b10, 2);
        force_step(8'ha0, 8'h00, 2'b00, 3);
        force_step(8'hd1, 8'h08, 2'b00, 3);
        rdchk("control c", `TMC_OFS_CTRL_C, 8'h00);
        // Every waveform mode; capture-top ones must cut the capture input.
        for (int m = 0; m < 16; m++)
        begin
            logic [3:0] mm;
            mm = 4'(m);
            wr(`TMC_OFS_CTRL_A, {6'h0, mm[1:0]});
            wr(`TMC_OFS_CTRL_B, {3'h0, mm[3:2], 3'h0});
            wr(`TMC_OFS_CTRL_C, 8'h00);
            @(posedge clk);
            #1 check("capture enable", {31'h0, ~(mm[3] & ~mm[0])}, {31'h0, cap_en});
        end
        check("strobes after zero writes", 32'h6, 32'(pulses_a + pulses_b));
        summarize();
    end

endmodule : sixteen_bit_timer_counter_core_tb_top
